// ---- rtl/rcf_pkg.sv ----
// constants shared by the reset cause flag registers
// assumes an 8-bit register port with a 12-bit address
package rcf_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	// documented register offsets
	localparam logic [11:0] BROWNOUT_CONTROL_OFS            = 12'h049;
	localparam logic [11:0] RESET_CAUSE_FLAGS_PRIMARY_OFS   = 12'h4F0;
	localparam logic [11:0] RESET_CAUSE_FLAGS_SECONDARY_OFS = 12'h4F1;
	// registers of our own: interrupt status and mask
	localparam logic [11:0] IRQ_STATUS_OFS = 12'h4F2;
	localparam logic [11:0] IRQ_MASK_OFS   = 12'h4F3;
	// field positions
	localparam int SOFT_BROWNOUT_ENABLE_BIT   = 7;
	localparam int BROWNOUT_CIRCUIT_READY_BIT = 0;
	localparam int STACK_OVERFLOW_BIT         = 7;
	localparam int STACK_UNDERFLOW_BIT        = 6;
	localparam int WINDOW_VIOLATION_BIT       = 5;
	localparam int WATCHDOG_TIMEOUT_BIT       = 4;
	localparam int RESET_PIN_BIT              = 3;
	localparam int RESET_OPCODE_BIT           = 2;
	localparam int POWER_ON_BIT               = 1;
	localparam int BROWNOUT_BIT               = 0;
	localparam int REGULATOR_READY_BIT        = 2;
	localparam int MEMORY_VIOLATION_BIT       = 1;
	localparam int CONFIG_LATCH_FAULT_BIT     = 0;
	// writable bit masks
	localparam logic [7:0] BROWNOUT_CONTROL_WMASK = 8'h80;
	localparam logic [7:0] SECONDARY_WMASK        = 8'h07;
	// values after power-on / brown-out reset
	localparam logic       SOFT_BROWNOUT_ENABLE_RST = 1'b1;
	localparam logic [7:0] PRIMARY_RST              = 8'h3C;
	localparam logic [2:0] SECONDARY_RST            = 3'h4;
	localparam logic [7:0] IRQ_RST                  = 8'h00;
	localparam logic [1:0] BROWNOUT_MODE_SOFT       = 2'h1;
	localparam int         NUM_EVENTS               = 8;
endpackage

// ---- rtl/rcf_sync.sv ----
// two flip-flop synchroniser for one asynchronous level
// assumes clk is the system clock
`timescale 1ns/1ps
`default_nettype none
module rcf_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic async_in,
	output var  logic sync_out
);
	logic meta;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta     <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule // rcf_sync
`default_nettype wire

// ---- rtl/rcf_edge.sv ----
// rising-edge pulse from a synchronous level
// assumes the input is already in the clk domain
`timescale 1ns/1ps
`default_nettype none
module rcf_edge (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic level_in,
	output var  logic pulse
);
	logic prev;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev <= 1'b0;
		end else begin
			prev <= level_in;
		end
	end
	assign pulse = level_in & ~prev;
endmodule // rcf_edge
`default_nettype wire

// ---- rtl/rcf_reset_cause.sv ----
// reset cause flag registers with brown-out control and interrupt
// assumes reset events arrive as strobes or levels from the reset generator;
// rst_n is the power-on/brown-out reset; other resets do not touch rst_n
//
// What this block does
// - registers at 0x049, 0x4F0, 0x4F1, eight bits
// - soft brown-out enable bit 7, power-up one
// - enable only effective when mode equals 01
// - bit 0 shows brown-out circuit armed
// - overflow sets bit 7; power-up clears
// - underflow sets bit 6; power-up clears
// - window violation clears bit 5; power-up sets
// - watchdog timeout clears bit 4; power-up sets
// - reset pin clears bit 3; power-up sets
// - reset opcode clears bit 2; power-up sets
// - power-on clears bit 1; firmware may restore
// - brown-out clears bit 0; kept otherwise
// - regulator fault clears secondary bit 2
// - memory violation clears secondary bit 1
// - secondary bit 0 shows latch corruption
// - firmware may write every flag inactive
// - only the event's own flags change
// - no self-clear; writes trigger no reset
`timescale 1ns/1ps
`default_nettype none
module rcf_reset_cause (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic [rcf_pkg::ADDR_W-1:0] addr,
	input  wire logic [rcf_pkg::DATA_W-1:0] wdata,
	input  wire logic                       wr_en,
	input  wire logic                       rd_en,
	output var  logic [rcf_pkg::DATA_W-1:0] rdata,
	input  wire logic                       power_on_event,
	input  wire logic                       brownout_event,
	input  wire logic                       stack_overflow_event,
	input  wire logic                       stack_underflow_event,
	input  wire logic                       window_violation_event,
	input  wire logic                       watchdog_timeout_event,
	input  wire logic                       external_reset_pin_event,
	input  wire logic                       reset_opcode_event,
	input  wire logic                       regulator_fault_event,
	input  wire logic                       memory_violation_event,
	input  wire logic                       config_latch_fault_event,
	input  wire logic [1:0]                 brownout_mode_config,
	input  wire logic                       brownout_circuit_ready_raw,
	output var  logic                       brownout_detect_enable,
	output var  logic                       irq
);
	import rcf_pkg::*;

	logic       soft_brownout_enable;
	logic       brownout_circuit_ready;
	logic [7:0] primary;
	logic [2:0] secondary;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;
	logic       pin_sync;
	logic       pin_pulse;
	logic       wr_bctl;
	logic       wr_pri;
	logic       wr_sec;
	logic [7:0] hw_clr_pri;
	logic [7:0] hw_set_pri;
	logic [2:0] hw_clr_sec;
	logic [7:0] evt_vec;

	// the ready status comes from an analog circuit in another domain
	rcf_sync u_ready_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (brownout_circuit_ready_raw),
		.sync_out (brownout_circuit_ready)
	);

	// the pin may be held high for a long time; flag once per assertion
	rcf_sync u_pin_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (external_reset_pin_event),
		.sync_out (pin_sync)
	);

	rcf_edge u_pin_edge (
		.clk      (clk),
		.rst_n    (rst_n),
		.level_in (pin_sync),
		.pulse    (pin_pulse)
	);

	assign wr_bctl = wr_en && (addr == BROWNOUT_CONTROL_OFS);
	assign wr_pri  = wr_en && (addr == RESET_CAUSE_FLAGS_PRIMARY_OFS);
	assign wr_sec  = wr_en && (addr == RESET_CAUSE_FLAGS_SECONDARY_OFS);

	always_comb begin
		hw_clr_pri = 8'h00;
		hw_set_pri = 8'h00;
		hw_clr_sec = 3'h0;
		hw_set_pri[STACK_OVERFLOW_BIT]   = stack_overflow_event;
		hw_set_pri[STACK_UNDERFLOW_BIT]  = stack_underflow_event;
		hw_clr_pri[WINDOW_VIOLATION_BIT] = window_violation_event;
		hw_clr_pri[WATCHDOG_TIMEOUT_BIT] = watchdog_timeout_event;
		hw_clr_pri[RESET_PIN_BIT]        = pin_pulse;
		hw_clr_pri[RESET_OPCODE_BIT]     = reset_opcode_event;
		hw_clr_pri[POWER_ON_BIT]         = power_on_event;
		hw_clr_pri[BROWNOUT_BIT]         = brownout_event;
		hw_clr_sec[REGULATOR_READY_BIT]  = regulator_fault_event;
		hw_clr_sec[MEMORY_VIOLATION_BIT] = memory_violation_event;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			soft_brownout_enable <= SOFT_BROWNOUT_ENABLE_RST;
		end else if (wr_bctl) begin
			soft_brownout_enable <= wdata[SOFT_BROWNOUT_ENABLE_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			brownout_detect_enable <= 1'b0;
		end else if (brownout_mode_config == BROWNOUT_MODE_SOFT) begin
			brownout_detect_enable <= soft_brownout_enable;
		end else begin
			// other modes: detector follows the mode, not this bit
			brownout_detect_enable <= brownout_mode_config[1];
		end
	end

	// hardware events win over a firmware write in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			primary <= PRIMARY_RST;
		end else begin
			if (wr_pri) begin
				primary <= (wdata & ~hw_clr_pri) | hw_set_pri;
			end else begin
				primary <= (primary & ~hw_clr_pri) | hw_set_pri;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			secondary <= SECONDARY_RST;
		end else begin
			if (wr_sec) begin
				secondary <= (wdata[2:0] & ~hw_clr_sec)
					| {2'b00, config_latch_fault_event};
			end else begin
				secondary <= (secondary & ~hw_clr_sec)
					| {2'b00, config_latch_fault_event};
			end
		end
	end

	// interrupt events: any flag moving to its active state
	assign evt_vec = {stack_overflow_event | stack_underflow_event,
		window_violation_event, watchdog_timeout_event, pin_pulse,
		reset_opcode_event, power_on_event | brownout_event,
		regulator_fault_event | memory_violation_event,
		config_latch_fault_event};

	// set wins over write-one-to-clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= IRQ_RST;
		end else if (wr_en && (addr == IRQ_STATUS_OFS)) begin
			irq_status <= (irq_status & ~wdata) | evt_vec;
		end else begin
			irq_status <= irq_status | evt_vec;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask <= IRQ_RST;
		end else if (wr_en && (addr == IRQ_MASK_OFS)) begin
			irq_mask <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(((irq_status & ~(wr_en && addr == IRQ_STATUS_OFS ? wdata : 8'h00))
				| evt_vec) & irq_mask);
		end
	end

	// read data one cycle after the strobe; zero otherwise
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (rd_en) begin
			unique case (addr)
				BROWNOUT_CONTROL_OFS:
					rdata <= {soft_brownout_enable, 6'h00, brownout_circuit_ready};
				RESET_CAUSE_FLAGS_PRIMARY_OFS:   rdata <= primary;
				RESET_CAUSE_FLAGS_SECONDARY_OFS: rdata <= {5'h00, secondary};
				IRQ_STATUS_OFS:                  rdata <= irq_status;
				IRQ_MASK_OFS:                    rdata <= irq_mask;
				default:                         rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end
endmodule // rcf_reset_cause
`default_nettype wire

// ---- verif/rcf_reset_cause_props.sv ----
// assertions on the ports of the reset cause flag registers
// assumes events are one-cycle pulses and reads answer one cycle late
`timescale 1ns/1ps
`default_nettype none
module rcf_reset_cause_props (
	input wire logic                       clk,
	input wire logic                       rst_n,
	input wire logic [rcf_pkg::ADDR_W-1:0] addr,
	input wire logic                       rd_en,
	input wire logic [rcf_pkg::DATA_W-1:0] rdata,
	input wire logic [1:0]                 brownout_mode_config,
	input wire logic                       brownout_detect_enable,
	input wire logic                       stack_overflow_event,
	input wire logic                       watchdog_timeout_event,
	input wire logic                       power_on_event,
	input wire logic                       memory_violation_event,
	input wire logic                       config_latch_fault_event
);
	import rcf_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic rd_pri;
	logic rd_sec;
	logic rd_map;
	assign rd_pri = rd_en && addr == RESET_CAUSE_FLAGS_PRIMARY_OFS;
	assign rd_sec = rd_en && addr == RESET_CAUSE_FLAGS_SECONDARY_OFS;
	assign rd_map = addr inside {BROWNOUT_CONTROL_OFS, RESET_CAUSE_FLAGS_PRIMARY_OFS,
		RESET_CAUSE_FLAGS_SECONDARY_OFS, IRQ_STATUS_OFS, IRQ_MASK_OFS};
	a_rdata_idle_zero: assert property (!rd_en |=> rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_unmapped_reads_zero: assert property (rd_en && !rd_map |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	a_control_gaps_zero: assert property (rd_en && addr == BROWNOUT_CONTROL_OFS
		|=> rdata[6:1] == 6'h00)
		else $error("control gap bits not zero");
	a_secondary_gaps_zero: assert property (rd_sec |=> rdata[7:3] == 5'h00)
		else $error("secondary gap bits not zero");
	a_detect_by_mode: assert property (brownout_mode_config != BROWNOUT_MODE_SOFT
		|=> brownout_detect_enable == $past(brownout_mode_config[1]))
		else $error("detect enable ignores mode");
	a_overflow_sets_flag: assert property (stack_overflow_event ##1 rd_pri
		|=> rdata[7])
		else $error("overflow flag not set");
	a_timeout_clears_flag: assert property (watchdog_timeout_event ##1 rd_pri
		|=> !rdata[4])
		else $error("timeout flag not cleared");
	a_power_on_clears: assert property (power_on_event ##1 rd_pri |=> !rdata[1])
		else $error("power-on flag not cleared");
	a_memory_clears_flag: assert property (memory_violation_event ##1 rd_sec
		|=> !rdata[1])
		else $error("memory flag not cleared");
	a_latch_sets_flag: assert property (config_latch_fault_event ##1 rd_sec
		|=> rdata[0])
		else $error("latch flag not set");
	cover property (stack_overflow_event ##1 rd_pri);
	cover property (config_latch_fault_event ##1 rd_sec);
	cover property (rd_en && !rd_map);
endmodule // rcf_reset_cause_props
bind rcf_reset_cause rcf_reset_cause_props i_props (.*);
`default_nettype wire

// ---- verif/rcf_reset_cause_test.sv ----
// self-checking bench for the reset cause flag registers
// assumes the checker is bound to the design by its own file
`timescale 1ns/1ps
`default_nettype none
module rcf_reset_cause_test;
	import rcf_pkg::*;
	// per event: primary toggle, secondary toggle, status bit
	localparam logic [23:0] EVT [11] = '{24'h80_0080, 24'h40_0080, 24'h20_0040,
		24'h10_0020, 24'h08_0010, 24'h04_0008, 24'h02_0004, 24'h01_0004,
		24'h00_0402, 24'h00_0202, 24'h00_0101};
	localparam int LIMIT = 4000;
	logic        clk;
	logic        rst_n;
	logic [11:0] addr;
	logic [7:0]  wdata;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  rdata;
	logic [10:0] ev;
	logic [1:0]  mode;
	logic        raw;
	logic        det;
	logic        irq;
	logic [31:0] seed;
	logic [7:0]  d;
	int          error_cnt = 0;
	int          comparisons = 0;
	int          cycles = 0;
	rcf_reset_cause i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .stack_overflow_event(ev[0]),
		.stack_underflow_event(ev[1]), .window_violation_event(ev[2]),
		.watchdog_timeout_event(ev[3]), .external_reset_pin_event(ev[4]),
		.reset_opcode_event(ev[5]), .power_on_event(ev[6]), .brownout_event(ev[7]),
		.regulator_fault_event(ev[8]), .memory_violation_event(ev[9]),
		.config_latch_fault_event(ev[10]), .brownout_mode_config(mode),
		.brownout_circuit_ready_raw(raw), .brownout_detect_enable(det), .irq(irq));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			error_cnt++;
			close_out();
		end
	end
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge clk);
		wr_en <= 1'b1;
		addr  <= a;
		wdata <= v;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	// the event leaves as the read of the flag register at address a goes out
	// reading the register at once lets the checker see the event-then-read pattern
	task automatic fire(input int i, input logic [11:0] a);
		@(posedge clk);
		ev[i] <= 1'b1;
		repeat ((i == 4) ? 4 : 1) @(posedge clk);
		ev    <= '0;
		rd_en <= 1'b1;
		addr  <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk);
		rd_en <= 1'b1;
		addr  <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		@(negedge clk);
		chk8($sformatf("reg %h", a), e, rdata);
	endtask
	task automatic reset_and_check();
		logic [11:0] ra [6];
		logic [7:0]  rv [6];
		ra = '{12'h049, 12'h4F0, 12'h4F1, 12'h4F2, 12'h4F3, 12'h123};
		rv = '{8'h80, 8'h3C, 8'h04, 8'h00, 8'h00, 8'h00};
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 6; k++)
			rdchk(ra[k], rv[k]);
		$display("test reset done");
	endtask
	initial begin
		logic [1:0] mv [4];
		logic [7:0] wv [4];
		logic [11:0] fa;
		mv = '{2'h1, 2'h1, 2'h2, 2'h0};
		wv = '{8'h00, 8'h80, 8'h00, 8'h80};
		{rst_n, addr, wdata, wr_en, rd_en, ev, raw} = '0;
		mode = 2'h1;
		seed = 32'hc47d;
		reset_and_check();
		for (int k = 0; k < 6; k++) begin
			seed = lfsr(seed);
			wr(RESET_CAUSE_FLAGS_PRIMARY_OFS, seed[7:0]);
			rdchk(RESET_CAUSE_FLAGS_PRIMARY_OFS, seed[7:0]);
			wr(BROWNOUT_CONTROL_OFS, seed[15:8]);
			rdchk(BROWNOUT_CONTROL_OFS, seed[15:8] & 8'h80);
			wr(RESET_CAUSE_FLAGS_SECONDARY_OFS, seed[23:16]);
			rdchk(RESET_CAUSE_FLAGS_SECONDARY_OFS, seed[23:16] & 8'h07);
			wr({4'h8, seed[31:24]}, seed[7:0]);
			rdchk({4'h8, seed[31:24]}, 8'h00);
		end
		$display("test writes done");
		wr(IRQ_MASK_OFS, 8'hFF);
		for (int i = 0; i < 11; i++) begin
			wr(RESET_CAUSE_FLAGS_PRIMARY_OFS, 8'h3F);
			wr(RESET_CAUSE_FLAGS_SECONDARY_OFS, 8'h06);
			wr(IRQ_STATUS_OFS, 8'hFF);
			fa = (i < 8) ? RESET_CAUSE_FLAGS_PRIMARY_OFS : RESET_CAUSE_FLAGS_SECONDARY_OFS;
			fire(i, fa);
			chk8("flags", (i < 8) ? 8'h3F ^ EVT[i][23:16] : 8'h06 ^ EVT[i][15:8], d);
			chk8("irq", 8'h01, {7'h00, irq});
			rdchk(fa ^ 12'h001, (i < 8) ? 8'h06 : 8'h3F);
			rdchk(IRQ_STATUS_OFS, EVT[i][7:0]);
		end
		wr(IRQ_STATUS_OFS, 8'hFF);
		wr(IRQ_MASK_OFS, 8'h7F);
		fire(0, RESET_CAUSE_FLAGS_PRIMARY_OFS);
		chk8("masked irq", 8'h00, {7'h00, irq});
		rdchk(IRQ_STATUS_OFS, 8'h80);
		$display("test events done");
		for (int j = 0; j < 4; j++) begin
			@(posedge clk);
			mode <= mv[j];
			wr(BROWNOUT_CONTROL_OFS, wv[j]);
			repeat (2) @(posedge clk);
			@(negedge clk);
			chk8("detect", {7'h00, j == 1 || j == 2}, {7'h00, det});
		end
		@(posedge clk);
		raw <= 1'b1;
		repeat (4) @(posedge clk);
		rdchk(BROWNOUT_CONTROL_OFS, 8'h81);
		raw <= 1'b0;
		$display("test brownout done");
		reset_and_check();
		close_out();
	end
endmodule // rcf_reset_cause_test
`default_nettype wire
